// file: src/sld_pkg.sv
// Constants and carrier types shared by the status lamp driver.
package sld_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int FLICKER_HALF_NS = 50000000;
  localparam int FLICKER_CYCLES = FLICKER_HALF_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 24;
  localparam logic [2:0] TICK_RST = 3'h0;
  localparam logic [DIV_W-1:0] DIV_RST = 24'h000000;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] UNIT_STATE_OFS = 8'h04;
  localparam logic [7:0] NET_STATE_OFS = 8'h08;
  localparam logic [7:0] PIN_STATUS_OFS = 8'h0c;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
  localparam logic [7:0] LAMP_OFS = 8'h18;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [2:0] UNIT_STATE_RST = 3'h0;
  localparam logic [7:0] NET_STATE_RST = 8'h00;
  localparam logic [5:0] IRQ_RST = 6'h00;
  // Control fields: bit 0 variant, bits 2:1 fieldbus.
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int CTRL_BUS_LSB = 1;
  localparam logic VARIANT_ACCESS = 1'b0;
  localparam logic [1:0] BUS_PROFINET = 2'h0;
  // Unit state codes.
  localparam logic [2:0] ST_POWER_UP = 3'h1;
  localparam logic [2:0] ST_STANDBY = 3'h2;
  localparam logic [2:0] ST_OP_ENABLED = 3'h3;
  localparam logic [2:0] ST_FAULT_REACT = 3'h4;
  localparam logic [2:0] ST_FAULT = 3'h5;
  // Network state fields and pattern codes.
  localparam int NET_PN_LSB = 0;
  localparam int NET_PN_ERR_BIT = 2;
  localparam int NET_GRN_LSB = 4;
  localparam int NET_RED_LSB = 6;
  localparam logic [1:0] PN_MASTER = 2'h1;
  localparam logic [1:0] PN_ONLINE = 2'h2;
  localparam logic [1:0] PN_INIT_DONE = 2'h3;
  localparam logic [1:0] PAT_ON = 2'h1;
  localparam logic [1:0] PAT_BLINK = 2'h2;
  localparam logic [1:0] PAT_FLICKER = 2'h3;
  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic safety_ok;
    logic aux_on;
    logic aux_uv;
    logic dc_ok;
    logic cap_full;
    logic cap_busy;
    logic [2:0] link;
    logic [2:0] act;
  } sld_sense_type;
  localparam sld_sense_type SENSE_RST = 12'h000;
  typedef struct packed {
    logic unit_state_lamp_green;
    logic unit_state_lamp_red;
    logic safety_supply_lamp_green;
    logic aux_lamp_green;
    logic aux_lamp_red;
    logic storage_bank_charge_lamp_green;
    logic network_status_lamp_green;
    logic network_status_lamp_red;
    logic [2:0] port_link_lamp_green;
  } sld_lamp_type;
  localparam sld_lamp_type LAMP_RST = 11'h000;
endpackage

// file: src/sld_status_lamp_driver.sv
// Status lamp driver with APB registers, flash timing and interrupts.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module sld_status_lamp_driver #(
  parameter int FLICKER_CYCLES = sld_pkg::FLICKER_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // APB slave
  input wire logic APB_PSEL_IN,
  input wire logic APB_PENABLE_IN,
  input wire logic APB_PWRITE_IN,
  input wire logic [7:0] APB_PADDR_IN,
  input wire logic [31:0] APB_PWDATA_IN,
  output logic APB_PREADY_OUT,
  output logic [31:0] APB_PRDATA_OUT,
  output logic APB_PSLVERR_OUT,
  // Monitor pins
  input wire sld_pkg::sld_sense_type SENSE_IN,
  // Lamps and interrupt
  output sld_pkg::sld_lamp_type LAMP_OUT,
  output logic IRQ_OUT
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  sld_pkg::sld_sense_type sense_meta_q;
  sld_pkg::sld_sense_type sense_q;
  sld_pkg::sld_sense_type sense_prev_q;
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      sense_meta_q <= sld_pkg::SENSE_RST;
      sense_q <= sld_pkg::SENSE_RST;
      sense_prev_q <= sld_pkg::SENSE_RST;
    end
    else
    begin
      sense_meta_q <= SENSE_IN;
      sense_q <= sense_meta_q;
      sense_prev_q <= sense_q;
    end
  end

  // ---------------------------------------------------------------
  // Shared flash divider
  // ---------------------------------------------------------------
  logic [sld_pkg::DIV_W-1:0] div_q;
  logic [2:0] tick_cnt_q;
  logic tick_q;
  logic flicker;
  logic blink;
  localparam int DIV_WIDTH = sld_pkg::DIV_W;
  localparam logic [sld_pkg::DIV_W-1:0] DIV_LAST = DIV_WIDTH'(FLICKER_CYCLES - 1);
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      div_q <= sld_pkg::DIV_RST;
      tick_q <= 1'b0;
    end
    else if (div_q == DIV_LAST)
    begin
      div_q <= sld_pkg::DIV_RST;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      tick_cnt_q <= sld_pkg::TICK_RST;
    else if (tick_q)
      tick_cnt_q <= tick_cnt_q + 1'b1;
  end
  assign flicker = tick_cnt_q[0];
  assign blink = tick_cnt_q[2];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [3:0] ctrl_q;
  logic [2:0] unit_state_q;
  logic [7:0] net_state_q;
  logic [5:0] irq_status_q;
  logic [5:0] irq_mask_q;
  logic [5:0] irq_event;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic slverr_d;
  logic slverr_q;
  logic wr_en;
  logic setup;
  sld_pkg::sld_lamp_type lamp_d;
  sld_pkg::sld_lamp_type lamp_q;
  assign setup = APB_PSEL_IN && !APB_PENABLE_IN;
  assign wr_en = APB_PSEL_IN && APB_PENABLE_IN && APB_PWRITE_IN;
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      ctrl_q <= sld_pkg::CTRL_RST;
      unit_state_q <= sld_pkg::UNIT_STATE_RST;
      net_state_q <= sld_pkg::NET_STATE_RST;
      irq_mask_q <= sld_pkg::IRQ_RST;
    end
    else if (wr_en)
    begin
      unique case (APB_PADDR_IN)
        sld_pkg::CTRL_OFS: ctrl_q <= APB_PWDATA_IN[3:0];
        sld_pkg::UNIT_STATE_OFS: unit_state_q <= APB_PWDATA_IN[2:0];
        sld_pkg::NET_STATE_OFS: net_state_q <= APB_PWDATA_IN[7:0];
        sld_pkg::IRQ_MASK_OFS: irq_mask_q <= APB_PWDATA_IN[5:0];
        default: ;
      endcase
    end
  end
  // Events: supply lost, undervoltage, DC link lost, port link change.
  assign irq_event = {sense_q.link ^ sense_prev_q.link,
                      sense_prev_q.dc_ok && !sense_q.dc_ok,
                      sense_q.aux_uv && !sense_prev_q.aux_uv,
                      sense_prev_q.safety_ok && !sense_q.safety_ok};
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      irq_status_q <= sld_pkg::IRQ_RST;
    else if (wr_en && APB_PADDR_IN == sld_pkg::IRQ_STATUS_OFS)
      irq_status_q <= (irq_status_q & ~APB_PWDATA_IN[5:0]) | irq_event;
    else
      irq_status_q <= irq_status_q | irq_event;
  end
  assign IRQ_OUT = |(irq_status_q & irq_mask_q);
  always_comb
  begin
    rdata_d = 32'h00000000;
    slverr_d = 1'b0;
    unique case (APB_PADDR_IN)
      sld_pkg::CTRL_OFS: rdata_d[3:0] = ctrl_q;
      sld_pkg::UNIT_STATE_OFS: rdata_d[2:0] = unit_state_q;
      sld_pkg::NET_STATE_OFS: rdata_d[7:0] = net_state_q;
      sld_pkg::PIN_STATUS_OFS: rdata_d[11:0] = sense_q;
      sld_pkg::IRQ_STATUS_OFS: rdata_d[5:0] = irq_status_q;
      sld_pkg::IRQ_MASK_OFS: rdata_d[5:0] = irq_mask_q;
      sld_pkg::LAMP_OFS: rdata_d[10:0] = lamp_q;
      default: slverr_d = 1'b1;
    endcase
  end
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      rdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end
    else if (setup)
    begin
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
    end
  end
  assign APB_PREADY_OUT = 1'b1;
  assign APB_PRDATA_OUT = rdata_q;
  assign APB_PSLVERR_OUT = slverr_q && APB_PSEL_IN && APB_PENABLE_IN;

  // ---------------------------------------------------------------
  // Lamp decode
  // ---------------------------------------------------------------
  logic access_variant;
  logic [1:0] bus_sel;
  logic [1:0] pn_code;
  logic [1:0] grn_pat;
  logic [1:0] red_pat;
  logic unit_fault;
  logic unit_flash;
  assign access_variant = ctrl_q[sld_pkg::CTRL_VARIANT_BIT] == sld_pkg::VARIANT_ACCESS;
  assign bus_sel = ctrl_q[sld_pkg::CTRL_BUS_LSB +: 2];
  assign pn_code = net_state_q[sld_pkg::NET_PN_LSB +: 2];
  assign grn_pat = net_state_q[sld_pkg::NET_GRN_LSB +: 2];
  assign red_pat = net_state_q[sld_pkg::NET_RED_LSB +: 2];
  assign unit_fault = unit_state_q == sld_pkg::ST_FAULT || unit_state_q == sld_pkg::ST_FAULT_REACT;
  assign unit_flash = unit_state_q == sld_pkg::ST_STANDBY || unit_state_q == sld_pkg::ST_POWER_UP;

  function automatic logic pattern(input logic [1:0] pat, input logic bl, input logic fl);
    logic res;
    res = 1'b0;
    unique case (pat)
      sld_pkg::PAT_ON: res = 1'b1;
      sld_pkg::PAT_BLINK: res = bl;
      sld_pkg::PAT_FLICKER: res = fl;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  always_comb
  begin
    lamp_d = sld_pkg::LAMP_RST;
    // Unit state lamp, red first.
    if (unit_fault)
      lamp_d.unit_state_lamp_red = 1'b1;
    else if (!sense_q.dc_ok)
      lamp_d.unit_state_lamp_red = blink;
    else if (unit_state_q == sld_pkg::ST_OP_ENABLED)
      lamp_d.unit_state_lamp_green = 1'b1;
    else if (unit_flash)
      lamp_d.unit_state_lamp_green = blink;
    lamp_d.safety_supply_lamp_green = sense_q.safety_ok;
    // Auxiliary voltage lamp on the access variant.
    if (access_variant)
    begin
      if (sense_q.aux_uv)
        lamp_d.aux_lamp_red = 1'b1;
      else
        lamp_d.aux_lamp_green = sense_q.aux_on;
    end
    // Charge lamp on the capacitor variant.
    else if (sense_q.cap_busy)
      lamp_d.storage_bank_charge_lamp_green = blink;
    else
      lamp_d.storage_bank_charge_lamp_green = sense_q.cap_full;
    // Network status lamp.
    if (bus_sel == sld_pkg::BUS_PROFINET)
    begin
      if (net_state_q[sld_pkg::NET_PN_ERR_BIT])
        lamp_d.network_status_lamp_red = 1'b1;
      else
      begin
        unique case (pn_code)
          sld_pkg::PN_MASTER: lamp_d.network_status_lamp_green = 1'b1;
          sld_pkg::PN_ONLINE:
          begin
            lamp_d.network_status_lamp_green = 1'b1;
            lamp_d.network_status_lamp_red = 1'b1;
          end
          sld_pkg::PN_INIT_DONE: lamp_d.network_status_lamp_red = blink;
          default: ;
        endcase
      end
    end
    else if (red_pat != 2'h0)
      lamp_d.network_status_lamp_red = pattern(red_pat, blink, flicker);
    else
      lamp_d.network_status_lamp_green = pattern(grn_pat, blink, flicker);
    // Port link lamps; the capacitor variant has two ports.
    lamp_d.port_link_lamp_green = sense_q.link & ~(sense_q.act & {3{flicker}});
    if (!access_variant)
      lamp_d.port_link_lamp_green[2] = 1'b0;
  end
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      lamp_q <= sld_pkg::LAMP_RST;
    else
      lamp_q <= lamp_d;
  end
  assign LAMP_OUT = lamp_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);

  chk_unit_op_green: assert property (
    !unit_fault && sense_q.dc_ok && unit_state_q == sld_pkg::ST_OP_ENABLED
    |=> LAMP_OUT.unit_state_lamp_green && !LAMP_OUT.unit_state_lamp_red)
    else $error("unit lamp not steady green in operation");
  chk_unit_standby_flash: assert property (
    sense_q.dc_ok && unit_flash
    |=> LAMP_OUT.unit_state_lamp_green == $past(blink) && !LAMP_OUT.unit_state_lamp_red)
    else $error("unit lamp not flashing green in standby");
  chk_unit_fault_red: assert property (
    unit_fault |=> LAMP_OUT.unit_state_lamp_red && !LAMP_OUT.unit_state_lamp_green)
    else $error("unit lamp not steady red on fault");
  chk_unit_dc_flash: assert property (
    !unit_fault && !sense_q.dc_ok
    |=> LAMP_OUT.unit_state_lamp_red == $past(blink) && !LAMP_OUT.unit_state_lamp_green)
    else $error("unit lamp not flashing red without DC link");
  chk_safety_follow: assert property (
    ##1 LAMP_OUT.safety_supply_lamp_green == $past(sense_q.safety_ok))
    else $error("safety lamp does not follow supply");
  chk_aux_green: assert property (
    access_variant && !sense_q.aux_uv
    |=> LAMP_OUT.aux_lamp_green == $past(sense_q.aux_on) && !LAMP_OUT.aux_lamp_red)
    else $error("aux lamp green wrong");
  chk_aux_uv_red: assert property (
    access_variant && sense_q.aux_uv |=> LAMP_OUT.aux_lamp_red && !LAMP_OUT.aux_lamp_green)
    else $error("aux lamp not red on undervoltage");
  chk_cap_charge: assert property (
    !access_variant && !sense_q.cap_busy
    |=> LAMP_OUT.storage_bank_charge_lamp_green == $past(sense_q.cap_full))
    else $error("charge lamp wrong when settled");
  chk_cap_busy_flash: assert property (
    !access_variant && sense_q.cap_busy |=> LAMP_OUT.storage_bank_charge_lamp_green == $past(blink))
    else $error("charge lamp not flashing while busy");
  chk_link_flash: assert property (
    sense_q.link[0] && sense_q.act[0] |=> LAMP_OUT.port_link_lamp_green[0] == !$past(flicker))
    else $error("port lamp not flashing with traffic");
  chk_link_dark: assert property (
    !sense_q.link[0] |=> !LAMP_OUT.port_link_lamp_green[0])
    else $error("port lamp lit without link");
  chk_link_steady: assert property (
    sense_q.link[1] && !sense_q.act[1] |=> LAMP_OUT.port_link_lamp_green[1])
    else $error("port lamp dark with idle link");
  chk_pn_error_red: assert property (
    bus_sel == sld_pkg::BUS_PROFINET && net_state_q[sld_pkg::NET_PN_ERR_BIT]
    |=> LAMP_OUT.network_status_lamp_red && !LAMP_OUT.network_status_lamp_green)
    else $error("network lamp not solid red on error");
  chk_pn_orange: assert property (
    bus_sel == sld_pkg::BUS_PROFINET && !net_state_q[sld_pkg::NET_PN_ERR_BIT]
    && pn_code == sld_pkg::PN_ONLINE
    |=> LAMP_OUT.network_status_lamp_red && LAMP_OUT.network_status_lamp_green)
    else $error("network lamp not orange when online");
  chk_pn_blink_red: assert property (
    bus_sel == sld_pkg::BUS_PROFINET && !net_state_q[sld_pkg::NET_PN_ERR_BIT]
    && pn_code == sld_pkg::PN_INIT_DONE
    |=> LAMP_OUT.network_status_lamp_red == $past(blink) && !LAMP_OUT.network_status_lamp_green)
    else $error("network lamp not blinking red after init");
  chk_bus_red_wins: assert property (
    bus_sel != sld_pkg::BUS_PROFINET && red_pat != 2'h0 |=> !LAMP_OUT.network_status_lamp_green)
    else $error("network green shown with red pattern");
  chk_flash_stable: assert property (
    !tick_q |=> $stable(tick_cnt_q))
    else $error("flash phase moved without a tick");
  chk_irq_level: assert property (
    irq_event[0] && irq_mask_q[0] |=> IRQ_OUT [*2])
    else $error("interrupt missing after masked-in event");

  cov_fault_seen: cover property (unit_fault ##1 LAMP_OUT.unit_state_lamp_red);
  cov_blink_toggle: cover property ($rose(blink));
  cov_irq_clear: cover property (IRQ_OUT ##1 wr_en ##1 !IRQ_OUT);
  cov_link_activity: cover property (sense_q.link[0] && sense_q.act[0] && flicker);
  cov_cap_flash: cover property (!access_variant && sense_q.cap_busy && blink);
endmodule // sld_status_lamp_driver

// file: test/sld_lamp_viewer.sv
// Operator's view of the unit state and network status lamps, reduced to colours.
`timescale 1ns/10ps
module sld_lamp_viewer (
  // Lamp drive from the block
  input wire sld_pkg::sld_lamp_type lamp_in,
  // Seen colour: 0 dark, 1 green, 2 red, 3 orange
  output logic [1:0] unit_colour_out,
  output logic [1:0] net_colour_out
);
  assign unit_colour_out = {lamp_in.unit_state_lamp_red, lamp_in.unit_state_lamp_green};
  assign net_colour_out = {lamp_in.network_status_lamp_red, lamp_in.network_status_lamp_green};
endmodule // sld_lamp_viewer

// file: test/status_lamp_driver_test.sv
// Self-checking bench for the status lamp driver.
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end \
  end
module status_lamp_driver_test;
  localparam int FLK = 4;
  localparam int LIMIT = 10000;
  localparam logic [10:0] ST_ON [6] = '{11'h100, 11'h100, 11'h100, 11'h500, 11'h300, 11'h300};
  localparam logic [10:0] ST_FL [6] = '{11'h000, 11'h400, 11'h400, 11'h000, 11'h000, 11'h000};
  localparam logic [10:0] PN_ON [4] = '{11'h100, 11'h110, 11'h118, 11'h100};
  localparam logic [10:0] PN_FL [4] = '{11'h000, 11'h000, 11'h000, 11'h008};
  localparam logic [7:0] OB_PAT [6] = '{8'h10, 8'h90, 8'hc0, 8'h20, 8'h40, 8'h30};
  localparam logic [10:0] OB_FL [6] = '{11'h000, 11'h008, 11'h008, 11'h010, 11'h000, 11'h010};
  localparam logic [7:0] RST_OFS [5] = '{sld_pkg::CTRL_OFS, sld_pkg::UNIT_STATE_OFS,
    sld_pkg::NET_STATE_OFS, sld_pkg::IRQ_STATUS_OFS, sld_pkg::IRQ_MASK_OFS};
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic last_err;
  logic [31:0] rd;
  sld_pkg::sld_sense_type sense = sld_pkg::SENSE_RST;
  sld_pkg::sld_lamp_type lamp;
  logic irq;
  logic [1:0] unit_col;
  logic [1:0] net_col;
  logic [10:0] ones;
  logic [10:0] zeros;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  int slips;
  // ---------------------------------------------------------------
  // Design and lamp viewer
  // ---------------------------------------------------------------
  sld_status_lamp_driver #(.FLICKER_CYCLES(FLK)) i_dut (.CORE_CLK_IN(clk), .RST_IN(rst),
    .APB_PSEL_IN(psel), .APB_PENABLE_IN(penable), .APB_PWRITE_IN(pwrite),
    .APB_PADDR_IN(paddr), .APB_PWDATA_IN(pwdata), .APB_PREADY_OUT(pready),
    .APB_PRDATA_OUT(prdata), .APB_PSLVERR_OUT(pslverr), .SENSE_IN(sense),
    .LAMP_OUT(lamp), .IRQ_OUT(irq));
  sld_lamp_viewer i_view (.lamp_in(lamp), .unit_colour_out(unit_col),
    .net_colour_out(net_col));
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_count++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
      @(posedge clk);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic look(input string nm, input logic [10:0] on_v, input logic [10:0] fl_v);
    repeat (6) @(posedge clk);
    ones = '0;
    zeros = '0;
    repeat (40)
    begin
      @(negedge clk);
      ones = ones | lamp;
      zeros = zeros | ~lamp;
    end
    @(posedge clk);
    `CHK(nm, {on_v | fl_v, ~on_v}, {ones, zeros})
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    `CHK("lamp reset", 12'h000, {irq, lamp})
    @(posedge clk);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'h0, RST_OFS[i], 32'h0);
      `CHK("reg reset", 33'h0, {last_err, rd})
    end
    apb(1'h0, 8'h1c, 32'h0);
    `CHK("unmapped rd", 33'h100000000, {last_err, rd})
    apb(1'h1, 8'h1c, 32'h5);
    `CHK("unmapped wr", 1'h1, last_err)
    sense.safety_ok <= 1'h1;
    look("no dc link", 11'h100, 11'h200);
    apb(1'h1, sld_pkg::UNIT_STATE_OFS, 32'h5);
    look("fault no dc", 11'h300, 11'h000);
    `CHK("unit red", 2'h2, unit_col)
    apb(1'h0, sld_pkg::LAMP_OFS, 32'h0);
    `CHK("lamp reg", 32'h300, rd)
    sense.dc_ok <= 1'h1;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'h1, sld_pkg::UNIT_STATE_OFS, 32'(i));
      look("unit state", ST_ON[i], ST_FL[i]);
    end
    apb(1'h1, sld_pkg::IRQ_MASK_OFS, 32'h1);
    sense.safety_ok <= 1'h0;
    look("safety off", 11'h200, 11'h000);
    apb(1'h0, sld_pkg::IRQ_STATUS_OFS, 32'h0);
    `CHK("irq set", 33'h100000001, {irq, rd})
    apb(1'h1, sld_pkg::IRQ_STATUS_OFS, 32'h1);
    apb(1'h0, sld_pkg::IRQ_STATUS_OFS, 32'h0);
    @(negedge clk);
    `CHK("irq clear", 33'h0, {irq, rd})
    @(posedge clk);
    sense.safety_ok <= 1'h1;
    sense.dc_ok <= 1'h0;
    repeat (8) @(posedge clk);
    apb(1'h0, sld_pkg::IRQ_STATUS_OFS, 32'h0);
    `CHK("irq masked", 33'h000000004, {irq, rd})
    apb(1'h1, sld_pkg::IRQ_MASK_OFS, 32'h4);
    @(negedge clk);
    `CHK("irq unmask", 1'h1, irq)
    @(posedge clk);
    apb(1'h1, sld_pkg::IRQ_STATUS_OFS, 32'h4);
    @(negedge clk);
    `CHK("irq w1c", 1'h0, irq)
    @(posedge clk);
    sense.dc_ok <= 1'h1;
    apb(1'h1, sld_pkg::UNIT_STATE_OFS, 32'h0);
    sense.aux_on <= 1'h1;
    look("aux on", 11'h180, 11'h000);
    sense.aux_uv <= 1'h1;
    look("aux low", 11'h140, 11'h000);
    sense.aux_on <= 1'h0;
    sense.aux_uv <= 1'h0;
    apb(1'h1, sld_pkg::CTRL_OFS, 32'h1);
    sense.cap_full <= 1'h1;
    sense.link <= 3'h7;
    look("cap full", 11'h123, 11'h000);
    sense.cap_busy <= 1'h1;
    look("cap busy", 11'h103, 11'h020);
    sense.cap_full <= 1'h0;
    sense.cap_busy <= 1'h0;
    look("cap empty", 11'h103, 11'h000);
    apb(1'h1, sld_pkg::CTRL_OFS, 32'h0);
    sense.act <= 3'h2;
    look("links", 11'h105, 11'h002);
    sense.link <= 3'h0;
    sense.act <= 3'h0;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, sld_pkg::NET_STATE_OFS, 32'(i));
      look("profinet", PN_ON[i], PN_FL[i]);
      if (i == 2)
        `CHK("orange", 2'h3, net_col)
    end
    apb(1'h1, sld_pkg::NET_STATE_OFS, 32'h5);
    look("comm error", 11'h108, 11'h000);
    `CHK("net red", 2'h2, net_col)
    apb(1'h1, sld_pkg::CTRL_OFS, 32'h2);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'h1, sld_pkg::NET_STATE_OFS, {24'h0, OB_PAT[i]});
      look("other bus", {6'h08, i == 0, i == 4, 3'h0}, OB_FL[i]);
    end
    apb(1'h1, sld_pkg::CTRL_OFS, 32'h0);
    apb(1'h1, sld_pkg::NET_STATE_OFS, 32'h3);
    apb(1'h1, sld_pkg::UNIT_STATE_OFS, 32'h2);
    repeat (6) @(posedge clk);
    slips = 0;
    repeat (64)
    begin
      @(negedge clk);
      if (lamp.unit_state_lamp_green !== lamp.network_status_lamp_red)
        slips++;
    end
    `CHK("in phase", 0, slips)
    @(posedge clk);
    apb(1'h0, sld_pkg::PIN_STATUS_OFS, 32'h0);
    `CHK("pin status", {20'h0, sense}, rd)
    apb(1'h0, sld_pkg::IRQ_STATUS_OFS, 32'h0);
    `CHK("irq events", 33'h00000003a, {irq, rd})
    end_of_test();
  end
endmodule // status_lamp_driver_test
